// >>> hw/fvr_top.sv
// What this block does
// RULE_01 - low three cutoff bits come from register 21, values 0 to 7
// RULE_02 - upper eight cutoff bits from register 22, making an 11-bit cutoff
// RULE_03 - bit 0 of register 23 routes voice 1 through the filter
// RULE_04 - register 24 bit 6 enables the high-pass path
// RULE_05 - register 24 bit 5 enables band-pass, bit 4 enables low-pass
// RULE_06 - register 24 holds volume and filter type; one write updates both
// RULE_07 - filter type bits independent; high-pass plus low-pass gives notch
// RULE_08 - host writes 79 to register 24 for high-pass at full volume
// RULE_09 - oscillator 3 readable at register 27, envelope 3 at register 28
// RULE_10 - sawtooth readback ramps 0 to 255 and wraps at oscillator 3 rate
// RULE_11 - triangle readback counts 0 up to 255 and back to 0
// RULE_12 - pulse readback alternates between 0 and 255
// RULE_13 - noise readback gives pseudo-random bytes
// RULE_14 - register 24 bit 7 mutes voice 3 audio; oscillator keeps running
// RULE_15 - register 27 follows raw waveform, untouched by the envelope
// RULE_16 - envelope 3 readback stays zero until voice 3 is gated on
// RULE_17 - writing 16 to register 18 selects triangle on voice 3, no gate
// RULE_18 - register 14 holds low byte of voice 3 frequency
// RULE_19 - voice 1 frequency is 16 bits in registers 0 and 1, rewritable anytime
// RULE_20 - voice 1 control 65 is pulse with gate; 64 pulse with gate released
// RULE_21 - register 3 holds upper voice 1 pulse width bits
// RULE_22 - host writes 143 to register 24 for full volume, voice 3 muted
// RULE_23 - register 5 holds attack in upper nibble, decay in lower
// RULE_24 - register 6 holds sustain in upper nibble, release in lower
// RULE_25 - control bit 0 gates the envelope, bit 4 selects triangle
// RULE_26 - master volume is low four bits of register 24, 0 silent, 15 max
`timescale 1ns/10ps

module fvr_top
  import fvr_pkg::*;
#(
  parameter int ENV_SHORTEN = 1
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire fvr_host_req_t    host_req,
  output logic [7:0]            host_rdata,
  output fvr_filter_ctrl_t      filter_ctrl,
  output fvr_voice_t            voice1,
  output fvr_voice_t            voice3,
  output logic [7:0]            osc3_wave,
  output logic [7:0]            env3_level,
  output logic                  voice3_audio_on
);

  // ==========================================================================
  // write-only register file
  logic [7:0] regs_reg  [NUM_WR_REGS];
  logic [7:0] regs_next [NUM_WR_REGS];

  always_comb
  begin
    for (int i = 0; i < NUM_WR_REGS; i++)
    begin
      regs_next[i] = rst ? REG_RESET : regs_reg[i];
    end
    // any register may be rewritten at any time, mid-note included
    if (!rst && host_req.cs && host_req.we && (int'(host_req.addr) < NUM_WR_REGS))
    begin
      regs_next[host_req.addr] = host_req.wdata;  // RULE_06 RULE_19
    end
  end

  always_ff @(posedge sys_clk)
  begin
    regs_reg <= regs_next;
  end

  // ==========================================================================
  // decoded control fields
  function automatic fvr_voice_t decode_voice(input logic [7:0] flo, input logic [7:0] fhi,
                                              input logic [7:0] plo, input logic [7:0] phi,
                                              input logic [7:0] ctl, input logic [7:0] ad,
                                              input logic [7:0] sr);
    fvr_voice_t v;
    v.freq         = {fhi, flo};
    v.pulse_width  = {phi[3:0], plo};
    v.ctrl         = ctl;
    v.attack       = ad[7:4];
    v.decay        = ad[3:0];
    v.sustain      = sr[7:4];
    v.release_rate = sr[3:0];
    return v;
  endfunction

  always_comb
  begin
    voice1 = decode_voice(regs_reg[REG_V1_FREQ_LO], regs_reg[REG_V1_FREQ_HI],  // RULE_19
                          regs_reg[REG_V1_PW_LO], regs_reg[REG_V1_PW_HI],      // RULE_21
                          regs_reg[REG_V1_CTRL],                               // RULE_20 RULE_25
                          regs_reg[REG_V1_ATK_DCY], regs_reg[REG_V1_SUS_REL]); // RULE_23 RULE_24
    voice3 = decode_voice(regs_reg[REG_V3_FREQ_LO], regs_reg[REG_V3_FREQ_HI],  // RULE_18
                          regs_reg[REG_V3_PW_LO], regs_reg[REG_V3_PW_HI],
                          regs_reg[REG_V3_CTRL],
                          regs_reg[REG_V3_ATK_DCY], regs_reg[REG_V3_SUS_REL]);
  end

  always_comb
  begin
    filter_ctrl.cutoff     = {regs_reg[REG_CUTOFF_HI], regs_reg[REG_CUTOFF_LO][2:0]};  // RULE_01 RULE_02
    filter_ctrl.route      = regs_reg[REG_FILT_ROUTE];                                  // RULE_03
    // independent enables, so high-pass with low-pass forms the notch
    filter_ctrl.highpass   = regs_reg[REG_FILT_TYPE_VOL][FT_HIGHPASS];  // RULE_04 RULE_07
    filter_ctrl.bandpass   = regs_reg[REG_FILT_TYPE_VOL][FT_BANDPASS];  // RULE_05
    filter_ctrl.lowpass    = regs_reg[REG_FILT_TYPE_VOL][FT_LOWPASS];   // RULE_05 RULE_07
    filter_ctrl.voice3_off = regs_reg[REG_FILT_TYPE_VOL][FT_V3_OFF];    // RULE_14
    filter_ctrl.volume     = regs_reg[REG_FILT_TYPE_VOL][3:0];          // RULE_26
    voice3_audio_on        = ~regs_reg[REG_FILT_TYPE_VOL][FT_V3_OFF];   // RULE_14
  end

  // ==========================================================================
  // oscillator 3: phase accumulator and noise shift register
  logic [ACC_W-1:0]   acc_reg;
  logic [ACC_W-1:0]   acc_next;
  logic [NOISE_W-1:0] lfsr_reg;
  logic [NOISE_W-1:0] lfsr_next;
  logic [7:0]         wave_reg;
  logic [7:0]         wave_next;

  function automatic logic [7:0] noise_byte(input logic [NOISE_W-1:0] s);
    return {s[22], s[20], s[16], s[13], s[11], s[7], s[4], s[2]};
  endfunction

  always_comb
  begin
    logic [7:0] saw_w;
    logic [7:0] tri_w;
    logic [7:0] pul_w;
    logic [7:0] noi_w;
    logic [7:0] mix;
    logic       any;
    saw_w = acc_reg[ACC_W-1 -: 8];                                        // RULE_10
    tri_w = acc_reg[ACC_W-1] ? ~acc_reg[ACC_W-2 -: 8] : acc_reg[ACC_W-2 -: 8];  // RULE_11
    pul_w = (acc_reg[ACC_W-1 -: 12] >= voice3.pulse_width) ? WAVE_MAX : WAVE_MIN;  // RULE_12
    noi_w = noise_byte(lfsr_reg);                                          // RULE_13
    mix   = WAVE_MAX;
    any   = 1'b0;
    // runs regardless of the voice 3 mute bit
    if (voice3.ctrl[CTRL_TEST])
    begin
      acc_next = '0;
    end
    else
    begin
      acc_next = acc_reg + {8'h00, voice3.freq};  // RULE_10
    end
    lfsr_next = lfsr_reg;
    if (!acc_reg[NOISE_CLK_B] && acc_next[NOISE_CLK_B])
    begin
      lfsr_next = {lfsr_reg[NOISE_W-2:0], lfsr_reg[22] ^ lfsr_reg[17]};  // RULE_13
    end
    // several waveforms at once combine by and-ing
    if (voice3.ctrl[CTRL_TRI])
    begin
      mix = mix & tri_w;  // RULE_17 RULE_25
      any = 1'b1;
    end
    if (voice3.ctrl[CTRL_SAW])
    begin
      mix = mix & saw_w;
      any = 1'b1;
    end
    if (voice3.ctrl[CTRL_PULSE])
    begin
      mix = mix & pul_w;
      any = 1'b1;
    end
    if (voice3.ctrl[CTRL_NOISE])
    begin
      mix = mix & noi_w;
      any = 1'b1;
    end
    // raw waveform, never scaled by the envelope
    wave_next = any ? mix : WAVE_MIN;  // RULE_15
    if (rst)
    begin
      acc_next  = '0;
      lfsr_next = NOISE_SEED;
      wave_next = WAVE_MIN;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    acc_reg  <= acc_next;
    lfsr_reg <= lfsr_next;
    wave_reg <= wave_next;
  end

  // ==========================================================================
  // envelope generator 3
  fvr_env_state_t state_reg;
  fvr_env_state_t state_next;
  logic [7:0]     level_reg;
  logic [7:0]     level_next;
  logic [31:0]    rate_cnt_reg;
  logic [31:0]    rate_cnt_next;
  logic           gate_prev_reg;
  logic           gate_prev_next;

  // clock cycles per one-level step, at least one
  function automatic logic [31:0] step_cycles(input logic [3:0] code, input logic is_attack);
    int ms;
    int cyc;
    ms  = is_attack ? ATTACK_MS[code] : ATTACK_MS[code] * DCY_FACTOR;
    cyc = (ms * CLK_KHZ) / ENV_STEPS / ENV_SHORTEN;
    if (cyc < 1)
    begin
      cyc = 1;
    end
    return 32'(cyc);
  endfunction

  always_comb
  begin
    logic        gate;
    logic [31:0] period;
    logic        step;
    logic [7:0]  sus;
    gate           = voice3.ctrl[CTRL_GATE];  // RULE_25
    sus            = {voice3.sustain, voice3.sustain};
    step           = 1'b0;
    state_next     = state_reg;
    level_next     = level_reg;
    gate_prev_next = gate;
    case (state_reg)
      ENV_ATTACK:  period = step_cycles(voice3.attack, 1'b1);
      ENV_DECAY:   period = step_cycles(voice3.decay, 1'b0);
      ENV_SUSTAIN: period = step_cycles(voice3.decay, 1'b0);
      default:     period = step_cycles(voice3.release_rate, 1'b0);
    endcase
    step          = (rate_cnt_reg >= period - 32'h0000_0001);
    rate_cnt_next = step ? 32'h0000_0000 : rate_cnt_reg + 32'h0000_0001;
    if (gate && !gate_prev_reg)
    begin
      state_next    = ENV_ATTACK;
      rate_cnt_next = 32'h0000_0000;
    end
    else if (!gate && gate_prev_reg)
    begin
      state_next    = ENV_RELEASE;
      rate_cnt_next = 32'h0000_0000;
    end
    else if (step)
    begin
      case (state_reg)
        ENV_IDLE:    level_next = 8'h00;  // RULE_16
        ENV_ATTACK:
        begin
          if (level_reg == WAVE_MAX)
          begin
            state_next = ENV_DECAY;
          end
          else
          begin
            level_next = level_reg + 8'h01;
          end
        end
        ENV_DECAY, ENV_SUSTAIN:
        begin
          if (level_reg > sus)
          begin
            level_next = level_reg - 8'h01;
          end
          else
          begin
            state_next = ENV_SUSTAIN;
          end
        end
        ENV_RELEASE:
        begin
          if (level_reg == 8'h00)
          begin
            state_next = ENV_IDLE;
          end
          else
          begin
            level_next = level_reg - 8'h01;
          end
        end
        default:
        begin
          state_next = ENV_IDLE;
          level_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg     <= ENV_IDLE;
      level_reg     <= 8'h00;
      rate_cnt_reg  <= 32'h0000_0000;
      gate_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      level_reg     <= level_next;
      rate_cnt_reg  <= rate_cnt_next;
      gate_prev_reg <= gate_prev_next;
    end
  end

  // ==========================================================================
  // read port
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb
  begin
    rdata_next = rst ? READ_NONE : rdata_reg;
    if (!rst && host_req.cs && !host_req.we)
    begin
      case (host_req.addr)
        REG_OSC3_READ: rdata_next = wave_reg;   // RULE_09 RULE_15
        REG_ENV3_READ: rdata_next = level_reg;  // RULE_09 RULE_16
        default:       rdata_next = READ_NONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    rdata_reg <= rdata_next;
  end

  assign host_rdata = rdata_reg;
  assign osc3_wave  = wave_reg;
  assign env3_level = level_reg;

endmodule

// >>> hw/fvr_pkg.sv
package fvr_pkg;

  // ==========================================================================
  // register map (byte offsets on the host port)
  localparam logic [4:0] REG_V1_FREQ_LO   = 5'h00;
  localparam logic [4:0] REG_V1_FREQ_HI   = 5'h01;
  localparam logic [4:0] REG_V1_PW_LO     = 5'h02;
  localparam logic [4:0] REG_V1_PW_HI     = 5'h03;
  localparam logic [4:0] REG_V1_CTRL      = 5'h04;
  localparam logic [4:0] REG_V1_ATK_DCY   = 5'h05;
  localparam logic [4:0] REG_V1_SUS_REL   = 5'h06;
  localparam logic [4:0] REG_V3_FREQ_LO   = 5'h0E;
  localparam logic [4:0] REG_V3_FREQ_HI   = 5'h0F;
  localparam logic [4:0] REG_V3_PW_LO     = 5'h10;
  localparam logic [4:0] REG_V3_PW_HI     = 5'h11;
  localparam logic [4:0] REG_V3_CTRL      = 5'h12;
  localparam logic [4:0] REG_V3_ATK_DCY   = 5'h13;
  localparam logic [4:0] REG_V3_SUS_REL   = 5'h14;
  localparam logic [4:0] REG_CUTOFF_LO    = 5'h15;
  localparam logic [4:0] REG_CUTOFF_HI    = 5'h16;
  localparam logic [4:0] REG_FILT_ROUTE   = 5'h17;
  localparam logic [4:0] REG_FILT_TYPE_VOL = 5'h18;
  localparam logic [4:0] REG_OSC3_READ    = 5'h1B;
  localparam logic [4:0] REG_ENV3_READ    = 5'h1C;
  localparam int         NUM_WR_REGS      = 25;
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam logic [7:0] READ_NONE        = 8'h00;

  // ==========================================================================
  // field positions
  localparam int CTRL_GATE     = 0;
  localparam int CTRL_TEST     = 3;
  localparam int CTRL_TRI      = 4;
  localparam int CTRL_SAW      = 5;
  localparam int CTRL_PULSE    = 6;
  localparam int CTRL_NOISE    = 7;
  localparam int FT_LOWPASS    = 4;
  localparam int FT_BANDPASS   = 5;
  localparam int FT_HIGHPASS   = 6;
  localparam int FT_V3_OFF     = 7;
  localparam int ROUTE_V1      = 0;

  // ==========================================================================
  // oscillator and noise constants
  localparam int          ACC_W       = 24;
  localparam int          NOISE_W     = 23;
  localparam int          NOISE_CLK_B = 19;
  localparam logic [22:0] NOISE_SEED  = 23'h7FFFF8;
  localparam logic [7:0]  WAVE_MAX    = 8'hFF;
  localparam logic [7:0]  WAVE_MIN    = 8'h00;

  // ==========================================================================
  // envelope timing: attack time per full ramp in ms, decay/release is 3x
  localparam int CLK_PERIOD_NS  = 50;
  localparam int CLK_KHZ        = 1000000 / CLK_PERIOD_NS;
  localparam int ENV_STEPS      = 256;
  localparam int DCY_FACTOR     = 3;
  localparam int ATTACK_MS [16] = '{2, 8, 16, 24, 38, 56, 68, 80,
                                    100, 250, 500, 800, 1000, 3000, 5000, 8000};

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       cs;
    logic       we;
    logic [4:0] addr;
    logic [7:0] wdata;
  } fvr_host_req_t;

  typedef struct packed {
    logic [10:0] cutoff;
    logic [7:0]  route;
    logic        highpass;
    logic        bandpass;
    logic        lowpass;
    logic        voice3_off;
    logic [3:0]  volume;
  } fvr_filter_ctrl_t;

  typedef struct packed {
    logic [15:0] freq;
    logic [11:0] pulse_width;
    logic [7:0]  ctrl;
    logic [3:0]  attack;
    logic [3:0]  decay;
    logic [3:0]  sustain;
    logic [3:0]  release_rate;
  } fvr_voice_t;

  typedef enum logic [2:0] {ENV_IDLE, ENV_ATTACK, ENV_DECAY, ENV_SUSTAIN, ENV_RELEASE} fvr_env_state_t;

endpackage

// >>> test/fvr_top_sva.sv
`timescale 1ns/10ps
module fvr_top_sva
  import fvr_pkg::*;
#(
  parameter int ENV_SHORTEN = 1
)
(
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire fvr_host_req_t    host_req,
  input wire logic [7:0]       host_rdata,
  input wire fvr_filter_ctrl_t filter_ctrl,
  input wire fvr_voice_t       voice1,
  input wire fvr_voice_t       voice3,
  input wire logic [7:0]       osc3_wave,
  input wire logic [7:0]       env3_level,
  input wire logic             voice3_audio_on
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================================
  // host writes and a waveform held for three cycles
  sequence s_wr(logic [4:0] a);
    host_req.cs && host_req.we && host_req.addr == a;
  endsequence
  sequence s_wave(logic [7:0] c);
    (voice3.ctrl == c) [*3];
  endsequence
  property p_cut_lo;
    s_wr(REG_CUTOFF_LO) |=> filter_ctrl.cutoff[2:0] == $past(host_req.wdata[2:0]);
  endproperty
  a_cut_lo: assert property (p_cut_lo) else $error("cutoff low bits wrong");
  property p_cut_hi;
    s_wr(REG_CUTOFF_HI) |=> filter_ctrl.cutoff[10:3] == $past(host_req.wdata);
  endproperty
  a_cut_hi: assert property (p_cut_hi) else $error("cutoff high byte wrong");
  property p_type_vol;
    s_wr(REG_FILT_TYPE_VOL) |=> {filter_ctrl.voice3_off, filter_ctrl.highpass, filter_ctrl.bandpass,
      filter_ctrl.lowpass, filter_ctrl.volume} == $past(host_req.wdata);
  endproperty
  a_type_vol: assert property (p_type_vol) else $error("type or volume wrong");
  property p_mute;
    s_wr(REG_FILT_TYPE_VOL) |=> voice3_audio_on == !$past(host_req.wdata[FT_V3_OFF]);
  endproperty
  a_mute: assert property (p_mute) else $error("voice 3 mute wrong");
  property p_saw;
    s_wave(8'h20) |-> 8'(osc3_wave - $past(osc3_wave)) inside {8'h00, 8'h01};
  endproperty
  a_saw: assert property (p_saw) else $error("sawtooth step wrong");
  property p_tri;
    s_wave(8'h10) ##0 !voice3.freq[15] |-> 8'(osc3_wave - $past(osc3_wave)) inside {8'h00, 8'h01, 8'hFF};
  endproperty
  a_tri: assert property (p_tri) else $error("triangle step wrong");
  property p_pulse;
    s_wave(8'h40) |-> osc3_wave inside {WAVE_MIN, WAVE_MAX};
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse level wrong");
  property p_env_idle;
    !voice3.ctrl[CTRL_GATE] && env3_level == 8'h00 |=> env3_level == 8'h00;
  endproperty
  a_env_idle: assert property (p_env_idle) else $error("envelope rose without gate");
endmodule

// >>> test/fvr_host_model.sv
`timescale 1ns/10ps
module fvr_host_model
  import fvr_pkg::*;
(
  input  wire logic       sys_clk,
  output fvr_host_req_t   host_req,
  input  wire logic [7:0] host_rdata
);
  // ==========================================================================
  // host cycles: driven after the falling edge, taken at the rising edge
  initial host_req = '0;
  // idle bus shows inverted leftovers, not the last request
  function automatic void drop_req();
    host_req = '{cs: 1'b0, we: ~host_req.we, addr: ~host_req.addr, wdata: ~host_req.wdata};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    host_req = '{cs: 1'b1, we: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    host_req = '{cs: 1'b1, we: 1'b0, addr: a, wdata: 8'hA5};
    @(posedge sys_clk);
    @(negedge sys_clk);
    d = host_rdata;
    drop_req();
  endtask
  task automatic idle();
    @(negedge sys_clk);
    drop_req();
  endtask
endmodule

// >>> test/fvr_top_bench.sv
`timescale 1ns/10ps
module fvr_top_bench
  import fvr_pkg::*;
();
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  fvr_host_req_t    host_req;
  logic [7:0]       host_rdata;
  fvr_filter_ctrl_t filter_ctrl;
  fvr_voice_t       voice1;
  fvr_voice_t       voice3;
  logic [7:0]       osc3_wave;
  logic [7:0]       env3_level;
  logic             voice3_audio_on;
  logic [7:0]       got;
  int               error_cnt = 0;
  int               total_checks = 0;
  int               cyc = 0;
  int               mdl [32] = '{default: 0};

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  fvr_top #(.ENV_SHORTEN(10000)) dut (.sys_clk(sys_clk), .rst(rst), .host_req(host_req),
    .host_rdata(host_rdata), .filter_ctrl(filter_ctrl), .voice1(voice1), .voice3(voice3),
    .osc3_wave(osc3_wave), .env3_level(env3_level), .voice3_audio_on(voice3_audio_on));
  fvr_host_model host (.sys_clk(sys_clk), .host_req(host_req), .host_rdata(host_rdata));

  // ==========================================================================
  // comparisons, verdict, bounded waits
  task automatic chk_out(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected output at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected read at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_to(input int t);
    int n;
    n = 0;
    while (cyc < t)
    begin
      @(negedge sys_clk);
      n++;
      if (n > 5000)
      begin
        error_cnt++;
        stop_test();
      end
    end
  endtask
  // ==========================================================================
  // register model and its checks
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a <= 5'd24)
      mdl[a] = d;
  endtask
  task automatic chk_filter();
    host.idle();
    chk_out(filter_ctrl.cutoff, {mdl[22][7:0], mdl[21][2:0]});
    chk_out(filter_ctrl.route, mdl[23][7:0]);
    chk_out(filter_ctrl.highpass, mdl[24][6]);
    chk_out({filter_ctrl.bandpass, filter_ctrl.lowpass}, mdl[24][5:4]);
    chk_out(filter_ctrl.volume, mdl[24][3:0]);
    chk_out({filter_ctrl.voice3_off, voice3_audio_on}, {mdl[24][7], ~mdl[24][7]});
  endtask
  task automatic chk_voice(input int b);
    fvr_voice_t v;
    host.idle();
    v = (b == 0) ? voice1 : voice3;
    chk_out(v.freq, {mdl[b+1][7:0], mdl[b][7:0]});
    chk_out(v.pulse_width, {mdl[b+3][3:0], mdl[b+2][7:0]});
    chk_out(v.ctrl, mdl[b+4][7:0]);
    chk_out({v.attack, v.decay, v.sustain, v.release_rate}, {mdl[b+5][7:0], mdl[b+6][7:0]});
  endtask
  task automatic env_chk(input logic [7:0] e);
    host.idle();
    wait_to(cyc + 600);
    host.rd(REG_ENV3_READ, got);
    chk_rd(got, e);
  endtask
  // sample mid-step, 16 cycles apart, from a zeroed accumulator
  task automatic osc_run(input logic [7:0] w, input int ns);
    int t0;
    logic [23:0] acc;
    logic [7:0] e;
    wr(REG_V3_CTRL, w | 8'h08);
    wr(REG_V3_CTRL, w);
    host.idle();
    t0 = cyc;
    for (int j = 0; j < ns; j++)
    begin
      wait_to(t0 + 16 * j + 4);
      host.rd(REG_OSC3_READ, got);
      acc = 24'((16 * j + 4) * 32'h1000);
      case (w)
        8'h20: e = acc[23:16];
        8'h10: e = acc[23] ? ~acc[22:15] : acc[22:15];
        default: e = (acc[23:12] >= 12'h800) ? WAVE_MAX : WAVE_MIN;
      endcase
      chk_rd(got, e);
    end
  endtask

  initial
  begin
    logic [255:0] seen;
    int nd;
    void'($urandom(57372));
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk_filter();
    chk_voice(14);
    $display("reset test done");
    for (int i = 0; i < 16; i++)
    begin
      wr(REG_CUTOFF_LO, 8'($urandom));
      wr(REG_CUTOFF_HI, 8'($urandom));
      wr(REG_FILT_ROUTE, 8'($urandom));
      wr(REG_FILT_TYPE_VOL, {4'(i), 4'($urandom)});
      chk_filter();
    end
    wr(REG_FILT_TYPE_VOL, 8'h4F);
    chk_filter();
    for (int a = 25; a < 32; a++)
      wr(5'(a), 8'($urandom));
    chk_filter();
    wr(REG_FILT_TYPE_VOL, 8'h8F);
    chk_filter();
    $display("filter test done");
    for (int a = 0; a < 21; a++)
      if (a != 4 && a != 18 && (a < 7 || a > 13))
        wr(5'(a), 8'($urandom));
    wr(REG_V1_CTRL, 8'h41);
    chk_voice(0);
    wr(REG_V1_CTRL, 8'h40);
    chk_voice(0);
    chk_voice(14);
    for (int a = 0; a < 32; a++)
      if (a != 27 && a != 28)
      begin
        host.rd(5'(a), got);
        chk_rd(got, READ_NONE);
      end
    $display("voice test done");
    // mid-run reset must clear the voice 1, voice 3 and filter registers again
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    mdl = '{default: 0};
    chk_filter();
    chk_voice(0);
    chk_voice(14);
    $display("second reset test done");
    wr(REG_V3_ATK_DCY, 8'h00);
    wr(REG_V3_SUS_REL, 8'hF0);
    wr(REG_V3_CTRL, 8'h10);
    chk_voice(14);
    env_chk(8'h00);
    wr(REG_V3_CTRL, 8'h11);
    env_chk(8'hFF);
    wr(REG_V3_CTRL, 8'h10);
    env_chk(8'h00);
    $display("envelope test done");
    wr(REG_V3_FREQ_LO, 8'h00);
    wr(REG_V3_FREQ_HI, 8'h10);
    wr(REG_V3_PW_LO, 8'h00);
    wr(REG_V3_PW_HI, 8'h08);
    osc_run(8'h20, 280);
    osc_run(8'h10, 270);
    osc_run(8'h40, 270);
    wr(REG_V3_CTRL, 8'h80);
    host.idle();
    seen = '0;
    nd = 0;
    for (int i = 0; i < 24; i++)
    begin
      wait_to(cyc + 256);
      host.rd(REG_OSC3_READ, got);
      nd += (seen[got] === 1'b1) ? 0 : 1;
      seen[got] = 1'b1;
    end
    chk_rd(8'(nd > 8), 8'h01);
    $display("oscillator test done");
    stop_test();
  end
endmodule

bind fvr_top fvr_top_sva #(.ENV_SHORTEN(ENV_SHORTEN)) u_sva (.sys_clk(sys_clk), .rst(rst),
  .host_req(host_req), .host_rdata(host_rdata), .filter_ctrl(filter_ctrl), .voice1(voice1),
  .voice3(voice3), .osc3_wave(osc3_wave), .env3_level(env3_level), .voice3_audio_on(voice3_audio_on));
